// file: motor_start_pkg.sv
// Package with register map, field layout and timing constants.
package motor_start_pkg;
    // Current values are in units of 1/100 of nominal motor current.
    localparam int CLOCK_HZ = 10_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
    localparam int WINDOW_MS = 200;
    localparam int DWELL_MS = 500;
    localparam int REVERSAL_TRIP_MS = 100;
    localparam int FORCE_TIMEOUT_MIN = 5;
    localparam int FORCE_TIMEOUT_MS = FORCE_TIMEOUT_MIN * 60 * 1000;
    localparam logic [15:0] LEVEL_STOPPED = 16'h000A;
    localparam logic [15:0] LEVEL_RUN_LOW = 16'h0014;
    localparam logic [15:0] LEVEL_RUN_HIGH = 16'h0078;
    localparam logic [15:0] LEVEL_REV_CURRENT = 16'h0014;
    localparam logic [15:0] LEVEL_REV_RATIO = 16'h0050;
    localparam logic [15:0] RESET_START_LEVEL = 16'h01F4;
    localparam logic [15:0] RESET_RATED_START = 16'h0258;
    localparam logic [15:0] RESET_FIXED_DELAY = 16'h2710;
    localparam logic [15:0] RESET_MULTIPLIER = 16'h2710;
    localparam logic [15:0] RESET_NOMINAL_A = 16'h0064;
    // Register byte addresses.
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_START_LEVEL = 8'h04;
    localparam logic [7:0] REG_RATED_START = 8'h08;
    localparam logic [7:0] REG_FIXED_DELAY = 8'h0C;
    localparam logic [7:0] REG_MULTIPLIER = 8'h10;
    localparam logic [7:0] REG_NOMINAL_A = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_RATIO = 8'h1C;
    localparam logic [7:0] REG_STALL_COUNT = 8'h20;
    localparam logic [7:0] REG_REV_COUNT = 8'h24;
    localparam logic [7:0] REG_STALL_FAULT = 8'h28;
    localparam logic [7:0] REG_REV_FAULT = 8'h2C;
    localparam logic [7:0] REG_PRIMARY = 8'h30;
    localparam int CTRL_CURVE_BIT = 0;
    localparam int CTRL_FORCE_BIT = 1;
    localparam int CTRL_BUTTON_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MOTOR_STOPPED = 2'b00,
        MOTOR_STARTING = 2'b01,
        MOTOR_RUNNING = 2'b10
    } motor_state_type;

    typedef struct packed {
        logic [15:0] start_event_count;
        logic [15:0] trip_event_count;
        logic [15:0] elapsed_delay_pct;
        logic [15:0] fault_max;
    } stage_record_type;
endpackage

// file: motor_start_supervision.sv
// Motor status, stall stage and phase reversal stage with AXI4-Lite access.
`timescale 1ns/10ps
module motor_start_supervision
    import motor_start_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int FORCE_MS = FORCE_TIMEOUT_MS
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Measured fundamental currents, per cent of nominal, and the panel button.
    input wire logic [15:0] phase_current_value,
    input wire logic [15:0] neg_seq_current,
    input wire logic [15:0] pos_seq_current,
    input wire logic panel_button,
    // Status and trip outputs.
    output logic motor_starting,
    output logic motor_running,
    output logic stall_start,
    output logic stall_trip,
    output logic reversal_start,
    output logic reversal_trip,
    output logic force_active,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic rst_meta, rst_n;
    logic [31:0] tick_count;
    logic tick;
    logic curve_inverse, force_flag, button_q;
    logic [15:0] start_level, rated_start_current, fixed_delay;
    logic [15:0] inverse_multiplier, nominal_amps;
    motor_state_type motor_state;
    logic [15:0] stopped_ms, window_ms;
    logic was_low;
    logic [31:0] force_ms;
    logic [31:0] stall_ms, stall_limit, rev_ms;
    logic [15:0] neg_pos_sequence_ratio;
    stage_record_type stall_rec, rev_rec;
    logic [31:0] inv_num, inv_den;
    logic [31:0] start_primary, rated_primary;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic aw_full, w_full, w_low;
    logic [31:0] read_word;
    logic read_ok;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_count <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_count == 32'(TICK_DIV - 1));
            if (tick_count == 32'(TICK_DIV - 1)) begin
                tick_count <= 32'h0;
            end else begin
                tick_count <= tick_count + 32'h1;
            end
        end
    end

    // Ratio of sequence currents in percent.
    always_comb begin
        if (pos_seq_current == 16'h0) begin
            neg_pos_sequence_ratio = 16'hFFFF;
        end else begin
            neg_pos_sequence_ratio =
                16'((32'(neg_seq_current) * 32'd100) / 32'(pos_seq_current));
        end
    end

    // Motor status machine with dwell and window counters.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            motor_state <= MOTOR_STOPPED;
            stopped_ms <= 16'h0;
            window_ms <= 16'h0;
            was_low <= 1'b0;
        end else begin
            if (phase_current_value < LEVEL_STOPPED) begin
                motor_state <= MOTOR_STOPPED;
                was_low <= 1'b1;
                window_ms <= 16'h0;
                if (tick && stopped_ms != 16'hFFFF) begin
                    stopped_ms <= stopped_ms + 16'h1;
                end
            end else begin
                if (tick && window_ms != 16'hFFFF) begin
                    window_ms <= window_ms + 16'h1;
                end
                case (motor_state)
                    MOTOR_STOPPED: begin
                        // Start after dwell and fast rise.
                        if (was_low && stopped_ms >= 16'(DWELL_MS) &&
                            window_ms < 16'(WINDOW_MS) &&
                            phase_current_value > start_level) begin
                            motor_state <= MOTOR_STARTING;
                        end else if (phase_current_value >= LEVEL_RUN_LOW &&
                            phase_current_value <= LEVEL_RUN_HIGH &&
                            window_ms >= 16'(WINDOW_MS)) begin
                            motor_state <= MOTOR_RUNNING;
                        end
                    end
                    MOTOR_STARTING: begin
                        if (phase_current_value >= LEVEL_RUN_LOW &&
                            phase_current_value <= LEVEL_RUN_HIGH) begin
                            motor_state <= MOTOR_RUNNING;
                        end
                    end
                    MOTOR_RUNNING: motor_state <= MOTOR_RUNNING;
                    default: motor_state <= MOTOR_STOPPED;
                endcase
                if (window_ms >= 16'(WINDOW_MS)) begin
                    was_low <= 1'b0;
                    stopped_ms <= 16'h0;
                end
            end
        end
    end

    assign motor_starting = (motor_state == MOTOR_STARTING);
    assign motor_running = (motor_state == MOTOR_RUNNING);

    // Inverse time, Tstart times squared current ratio.
    assign inv_num = 32'(rated_start_current) * 32'(rated_start_current);
    assign inv_den = (phase_current_value == 16'h0) ? 32'h1 :
        32'(phase_current_value) * 32'(phase_current_value);
    // Curve selection between fixed and inverse delay.
    always_comb begin
        if (curve_inverse) begin
            stall_limit = 32'((64'(inv_num) * 64'(inverse_multiplier)) /
                64'(inv_den));
        end else begin
            stall_limit = 32'(fixed_delay);
        end
        if (stall_limit == 32'h0) begin
            stall_limit = 32'h1;
        end
    end

    // Stall stage timing, on fundamental current.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stall_start <= 1'b0;
            stall_trip <= 1'b0;
            stall_ms <= 32'h0;
            stall_rec <= '0;
        end else if (!motor_starting ||
            phase_current_value < LEVEL_RUN_HIGH) begin
            // Release below 120 percent; only when starting.
            stall_start <= 1'b0;
            stall_trip <= 1'b0;
            stall_ms <= 32'h0;
        end else begin
            if (!stall_start) begin
                stall_rec.start_event_count <=
                    stall_rec.start_event_count + 16'h1;
                stall_rec.fault_max <= 16'h0;
            end
            stall_start <= 1'b1;
            if (phase_current_value > stall_rec.fault_max) begin
                stall_rec.fault_max <= phase_current_value;
            end
            if (tick && !stall_trip) begin
                stall_ms <= stall_ms + 32'h1;
                stall_rec.elapsed_delay_pct <=
                    16'(((stall_ms + 32'h1) * 32'd100) / stall_limit);
                if (stall_ms + 32'h1 >= stall_limit) begin
                    stall_trip <= 1'b1;
                    stall_rec.trip_event_count <=
                        stall_rec.trip_event_count + 16'h1;
                end
            end
        end
    end

    // Phase reversal start and 100 ms trip.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reversal_start <= 1'b0;
            reversal_trip <= 1'b0;
            rev_ms <= 32'h0;
            rev_rec <= '0;
        end else if (!motor_starting ||
            neg_pos_sequence_ratio <= LEVEL_REV_RATIO ||
            phase_current_value <= LEVEL_REV_CURRENT) begin
            reversal_start <= 1'b0;
            reversal_trip <= 1'b0;
            rev_ms <= 32'h0;
        end else begin
            if (!reversal_start) begin
                rev_rec.start_event_count <=
                    rev_rec.start_event_count + 16'h1;
                rev_rec.fault_max <= 16'h0;
            end
            reversal_start <= 1'b1;
            if (neg_pos_sequence_ratio > rev_rec.fault_max) begin
                rev_rec.fault_max <= neg_pos_sequence_ratio;
            end
            if (tick && !reversal_trip) begin
                rev_ms <= rev_ms + 32'h1;
                rev_rec.elapsed_delay_pct <= 16'(((rev_ms + 32'h1) *
                    32'd100) / 32'(REVERSAL_TRIP_MS));
                if (rev_ms + 32'h1 >= 32'(REVERSAL_TRIP_MS)) begin
                    reversal_trip <= 1'b1;
                    rev_rec.trip_event_count <=
                        rev_rec.trip_event_count + 16'h1;
                end
            end
        end
    end

    // Timeout restarts on flag set and on each button press.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            force_ms <= 32'h0;
            button_q <= 1'b0;
        end else begin
            button_q <= panel_button;
            if (!force_flag || (panel_button && !button_q)) begin
                force_ms <= 32'h0;
            end else if (tick && force_flag &&
                force_ms < 32'(FORCE_MS)) begin
                force_ms <= force_ms + 32'h1;
            end
        end
    end
    assign force_active = force_flag;

    assign start_primary = 32'(start_level) * 32'(nominal_amps) / 32'd100;
    assign rated_primary =
        32'(rated_start_current) * 32'(nominal_amps) / 32'd100;

    // Write channel: address and data taken in either order.
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_low <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_low <= s_axi_wstrb[0];
            end
            if (aw_full && w_full) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr <= REG_NOMINAL_A) ?
                    RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Settings registers; the strobe bit 0 taken with the data gates them.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            curve_inverse <= 1'b0;
            force_flag <= 1'b0;
            start_level <= RESET_START_LEVEL;
            // Rated start current default 6.00 times nominal.
            rated_start_current <= RESET_RATED_START;
            fixed_delay <= RESET_FIXED_DELAY;
            inverse_multiplier <= RESET_MULTIPLIER;
            nominal_amps <= RESET_NOMINAL_A;
        end else begin
            // Timeout clears the shared test flag.
            if (force_flag && force_ms >= 32'(FORCE_MS)) begin
                force_flag <= 1'b0;
            end
            if (aw_full && w_full && w_low) begin
                case (aw_addr)
                    REG_CONTROL: begin
                        curve_inverse <= w_data[CTRL_CURVE_BIT];
                        force_flag <= w_data[CTRL_FORCE_BIT];
                    end
                    // Software keeps this below real start current.
                    REG_START_LEVEL: start_level <= w_data[15:0];
                    REG_RATED_START: rated_start_current <= w_data[15:0];
                    REG_FIXED_DELAY: fixed_delay <= w_data[15:0];
                    REG_MULTIPLIER: inverse_multiplier <= w_data[15:0];
                    REG_NOMINAL_A: nominal_amps <= w_data[15:0];
                    default: nominal_amps <= nominal_amps;
                endcase
            end
        end
    end

    always_comb begin
        read_ok = 1'b1;
        case (s_axi_araddr)
            REG_CONTROL: read_word = {29'h0, button_q, force_flag,
                curve_inverse};
            REG_START_LEVEL: read_word = {16'h0, start_level};
            REG_RATED_START: read_word = {16'h0, rated_start_current};
            REG_FIXED_DELAY: read_word = {16'h0, fixed_delay};
            REG_MULTIPLIER: read_word = {16'h0, inverse_multiplier};
            REG_NOMINAL_A: read_word = {16'h0, nominal_amps};
            REG_STATUS: read_word = {24'h0, force_flag, reversal_trip,
                reversal_start, stall_trip, stall_start, motor_running,
                motor_starting, motor_state == MOTOR_STOPPED};
            REG_RATIO: read_word = {16'h0, neg_pos_sequence_ratio};
            REG_STALL_COUNT: read_word = {stall_rec.trip_event_count,
                stall_rec.start_event_count};
            REG_REV_COUNT: read_word = {rev_rec.trip_event_count,
                rev_rec.start_event_count};
            REG_STALL_FAULT: read_word = {stall_rec.fault_max,
                stall_rec.elapsed_delay_pct};
            REG_REV_FAULT: read_word = {rev_rec.fault_max,
                rev_rec.elapsed_delay_pct};
            REG_PRIMARY: read_word = {rated_primary[15:0],
                start_primary[15:0]};
            default: begin
                read_word = 32'h0;
                read_ok = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    stall_release_a: assert property (@(posedge clock) disable iff (!rst_n)
        phase_current_value < LEVEL_RUN_HIGH |=> !stall_start)
        else $error("stall stage held below release level");
    stall_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !motor_starting |=> !stall_start && !stall_trip)
        else $error("stall stage active outside starting");
    reversal_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        reversal_trip |-> $past(reversal_start))
        else $error("reversal trip without prior start");
    stopped_state_a: assert property (@(posedge clock) disable iff (!rst_n)
        phase_current_value < LEVEL_STOPPED |=> !motor_starting
        && !motor_running)
        else $error("motor not stopped at low current");
    start_count_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(stall_start) |-> stall_rec.start_event_count ==
        $past(stall_rec.start_event_count) + 16'h1)
        else $error("stall start not counted");
    force_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        force_flag && force_ms >= 32'(FORCE_MS) && !(aw_full && w_full)
        |=> !force_flag)
        else $error("force flag not cleared on timeout");
    trip_pct_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(reversal_trip) |-> rev_rec.elapsed_delay_pct == 16'h0064)
        else $error("elapsed percent not 100 at trip");
    running_band_a: assert property (@(posedge clock) disable iff (!rst_n)
        motor_starting && phase_current_value >= LEVEL_RUN_LOW &&
        phase_current_value <= LEVEL_RUN_HIGH |=> motor_running)
        else $error("running band not entered");
endmodule

// file: current_front_end.sv
// Behavioural model of the current measurement front end and panel.
`timescale 1ns/10ps
module current_front_end (
    // Clock.
    input wire logic clock,
    // Quantities commanded by the bench.
    input wire logic [15:0] set_current,
    input wire logic [15:0] set_neg,
    input wire logic [15:0] set_pos,
    input wire logic set_button,
    // Measured quantities seen by the block.
    output logic [15:0] phase_current_value,
    output logic [15:0] neg_seq_current,
    output logic [15:0] pos_seq_current,
    output logic panel_button
);
    // Fundamental magnitudes only.
    // Harmonics are never modelled, so the block only sees fundamentals.
    always_ff @(posedge clock) begin
        phase_current_value <= set_current;
        neg_seq_current <= set_neg;
        pos_seq_current <= set_pos;
        panel_button <= set_button;
    end
endmodule

// file: motor_start_supervision_test.sv
// Self-checking bench for the motor start supervision block.
`timescale 1ns/10ps
module motor_start_supervision_test;
    import motor_start_pkg::*;
    logic clock = 0, resetn = 0, set_button = 0;
    logic [15:0] set_current = 0, set_neg = 0, set_pos = 16'h0064;
    logic [15:0] cur, neg, pos;
    logic button, starting, running, s_start, s_trip, r_start, r_trip, force_on;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    int n_mismatch = 0, n_tests = 0;
    always #50 clock = ~clock;
    current_front_end u_fe (.clock(clock), .set_current(set_current),
        .set_neg(set_neg), .set_pos(set_pos), .set_button(set_button),
        .phase_current_value(cur), .neg_seq_current(neg),
        .pos_seq_current(pos), .panel_button(button));
    motor_start_supervision #(.TICK_DIV(10), .FORCE_MS(50)) u_dut (
        .clock(clock), .resetn(resetn), .phase_current_value(cur),
        .neg_seq_current(neg), .pos_seq_current(pos), .panel_button(button),
        .motor_starting(starting), .motor_running(running),
        .stall_start(s_start), .stall_trip(s_trip), .reversal_start(r_start),
        .reversal_trip(r_trip), .force_active(force_on),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] expected);
        n_tests++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, expected, seen);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return starting;
            1: return running;
            2: return s_start;
            3: return s_trip;
            4: return r_trip;
            default: return !force_on;
        endcase
    endfunction
    // Waits at most limit cycles for a status output to go high, or for force_active to go low.
    task automatic wait_high(input int s, input int limit);
        int n;
        for (n = 0; n < limit && sig(s) !== 1'b1; n++) @(posedge clock);
        if (n == limit) begin
            check("wait timeout", s, 32'hFFFF);
            complete_run();
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 100 && (awvalid || wvalid || !bvalid); n++) begin
            @(posedge clock);
            if (awready && awvalid) awvalid <= 0;
            if (wready && wvalid) wvalid <= 0;
            if (bvalid && !awvalid && !wvalid) n = 200;
        end
        if (n < 200) begin
            check("write timeout", n, 32'd200);
            complete_run();
        end
        bready <= 0;
        @(posedge clock);
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        int n;
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 100 && !(rvalid && !arvalid); n++) begin
            @(posedge clock);
            if (arready && arvalid) arvalid <= 0;
        end
        if (n == 100) begin
            check("read timeout", n, 32'd0);
            complete_run();
        end
        d = rdata;
        rready <= 0;
        @(posedge clock);
    endtask
    // Holds the motor stopped past the dwell, then applies a start current.
    task automatic start_motor(input logic [15:0] c);
        set_current <= 0;
        repeat (6000) @(posedge clock);
        set_current <= c;
        wait_high(0, 2100);
    endtask
    task automatic scen_registers();
        axi_read(REG_RATED_START, rd);
        check("rated start", rd, 32'h0000_0258);
        axi_read(REG_PRIMARY, rd);
        check("primary", rd, 32'h0258_01F4);
        axi_read(8'h40, rd);
        check("unmapped resp", rresp, RESP_SLVERR);
        axi_write(8'h40, 32'h0);
        check("unmapped write", bresp, RESP_SLVERR);
    endtask
    task automatic scen_reversal_stall();
        axi_write(REG_FIXED_DELAY, 32'h32);
        check("write resp", bresp, RESP_OKAY);
        set_neg <= 16'h005A;
        start_motor(16'h0226);
        axi_read(REG_RATIO, rd);
        check("ratio", rd[15:0], 16'h005A);
        wait_high(2, 20);
        repeat (400) @(posedge clock);
        check("stall early", {s_trip, r_trip}, 0);
        wait_high(3, 200);
        check("reversal early", {r_start, r_trip}, 2'b10);
        wait_high(4, 700);
        set_current <= 16'h0032; set_neg <= 0;
        wait_high(1, 2100);
        check("released", {starting, s_start, r_start}, 0);
        axi_read(REG_REV_COUNT, rd);
        check("reversal counts", rd, 32'h0001_0001);
        axi_read(REG_REV_FAULT, rd);
        check("elapsed pct", rd[15:0], 16'h0064);
        axi_read(REG_STALL_FAULT, rd);
        check("max current", rd[31:16], 16'h0226);
    endtask
    task automatic scen_inverse();
        axi_write(REG_CONTROL, 32'h1);
        axi_write(REG_MULTIPLIER, 32'h1E);
        axi_write(REG_START_LEVEL, 32'hFA);
        start_motor(16'h012C);
        wait_high(2, 20);
        repeat (1080) @(posedge clock);
        check("inverse early", s_trip, 0);
        wait_high(3, 250);
    endtask
    task automatic scen_soft_start();
        int n;
        logic seen;
        seen = 0;
        set_current <= 0;
        repeat (6000) @(posedge clock);
        set_current <= 16'h0032;
        for (n = 0; n < 3000 && running !== 1'b1; n++) begin
            @(posedge clock);
            seen = seen | starting;
        end
        check("soft start", {seen, running}, 2'b01);
        set_current <= 16'h0005;
        repeat (20) @(posedge clock);
        axi_read(REG_STATUS, rd);
        check("stopped", {rd[0], running}, 2'b10);
    endtask
    task automatic scen_force();
        axi_write(REG_CONTROL, 32'h2);
        check("force set", force_on, 1);
        repeat (400) @(posedge clock);
        set_button <= 1;
        repeat (400) @(posedge clock);
        check("force held", force_on, 1);
        set_button <= 0;
        wait_high(5, 200);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1;
        repeat (4) @(posedge clock);
        scen_registers();
        scen_reversal_stall();
        scen_soft_start();
        scen_force();
        scen_inverse();
        complete_run();
    end
endmodule
